// File: shared/pxenh_map.svh
// Register offsets, field positions, reset values and counts of the pixel stage
`ifndef PXENH_MAP_SVH
`define PXENH_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PXE_PAGE_ADDR 8'h2a
`define PXE_CTRL_ADDR 8'h4a
`define PXE_STAT_ADDR 8'h4b

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PXE_PAGE_RST 8'h00
`define PXE_CTRL_RST 8'he1
`define PXE_ZERO8 8'h00

// ----------------------------------------------------------------------
// Page register fields
// ----------------------------------------------------------------------
`define PXE_PG_HI 7
`define PXE_PG_LO 6
`define PXE_WB_BIT 5

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PXE_C_EDGE 0
`define PXE_C_PRE 1
`define PXE_C_POST 2
`define PXE_C_RELOAD 3
`define PXE_C_DEONLY 4
`define PXE_C_HSPOL 5
`define PXE_C_VSPOL 6
`define PXE_C_DEPOL 7

// ----------------------------------------------------------------------
// Data limits and counts
// ----------------------------------------------------------------------
`define PXE_BYTE_MAX 8'hff
`define PXE_BYTE_MIN 8'h00
`define PXE_LOW2 2'h0
`define PXE_FRAME_GAP 16'h0100
`define PXE_FIFO_DEPTH 8
`define PXE_TAB_ENTRIES 256

`endif

// File: shared/pxenh_pkg.sv
// Types shared by the pixel output and enhancement stage
package pxenh_pkg;

   // -------------------------------------------------------------------
   // Register page selected by the page field
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      PXE_PAGE_CFG,
      PXE_PAGE_RED,
      PXE_PAGE_GREEN,
      PXE_PAGE_BLUE
   } pxe_page_t;

   // -------------------------------------------------------------------
   // Dither algorithm chosen per subpixel
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      PXE_ALG_DEFAULT,
      PXE_ALG_BW_PIXEL,
      PXE_ALG_FULL_SUB,
      PXE_ALG_LOW_END
   } pxe_alg_t;

   // -------------------------------------------------------------------
   // Table load state
   // -------------------------------------------------------------------
   typedef enum logic {
      PXE_LD_INIT,
      PXE_LD_LOCKED
   } pxe_load_t;

endpackage

// File: src/pxenh_fifo.sv
// Parameterised valid/ready FIFO between the enhancement pipe and the panel
module pxenh_fifo
#(
   parameter int WIDTH = 27,
   parameter int DEPTH = 8
)
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
   logic [AW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign o_in_ready = (cnt_reg != DEPTH[AW:0]);
   assign o_out_valid = (cnt_reg != '0);
   assign o_out_data = mem[rptr_reg];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   function automatic logic [AW-1:0] pxe_inc(input logic [AW-1:0] p);
      begin
         if (p == AW'(DEPTH - 1))
            return '0;
         return p + AW'(1);
      end
   endfunction

   always_comb
   begin
      wptr_next = push ? pxe_inc(wptr_reg) : wptr_reg;
      rptr_next = pop ? pxe_inc(rptr_reg) : rptr_reg;
      cnt_next = cnt_reg;
      if (push && !pop)
         cnt_next = cnt_reg + (AW+1)'(1);
      else if (pop && !push)
         cnt_next = cnt_reg - (AW+1)'(1);
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage needs no reset; only counted words are ever read
   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[wptr_reg] <= i_in_data;
   end
endmodule // pxenh_fifo

// File: src/pxenh_top.sv
// Pixel output stage: dithering, white balance tables, output edge select
// Contract
// - Edge select 1 rising, 0 falling launch
// - Output edge is register-set, input independent
// - Three 256x8 tables, host read and write except entry 0x2a (page address)
// - Balance on: subpixel replaced by table entry
// - Host loads tables over register slave port
// - 8-bit entries need post-table dither enabled
// - Page field selects config or color table
// - Page bit 5 enables white balance
// - Table writes refused after load unless reload
// - Reload allowed live without stream glitches
// - Reloads may be partial; first load full
// - Dither drives 6 bits, low bits zero
// - Two independent dithers, before and after
// - Dither widens to 9 bits, picks algorithm
// - Default plus three special-case algorithms
// - Temporal and spatial dithering combined
// - Pattern cell adds one or nothing
`include "pxenh_map.svh"

module pxenh_top
   import pxenh_pkg::*;
#(
   parameter logic [15:0] FRAME_GAP = `PXE_FRAME_GAP,
   parameter int FIFO_DEPTH = `PXE_FIFO_DEPTH
)
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic i_pix_valid,
   output logic o_pix_ready,
   input wire logic [7:0] i_red,
   input wire logic [7:0] i_green,
   input wire logic [7:0] i_blue,
   input wire logic i_hsync,
   input wire logic i_vsync,
   input wire logic i_de,
   input wire logic i_panel_ready,
   output logic o_pix_valid,
   output logic [7:0] o_red,
   output logic [7:0] o_green,
   output logic [7:0] o_blue,
   output logic o_hsync,
   output logic o_vsync,
   output logic o_de
);
   localparam int FW = 27;

   // -------------------------------------------------------------------
   // Dither function
   // -------------------------------------------------------------------
   function automatic logic [7:0] pxe_dither(input logic [7:0] d,
      input logic bw, input logic [1:0] fr, input logic x, input logic y);
      logic [8:0] ext;
      logic [5:0] t;
      logic [2:0] rank;
      logic inc;
      pxe_alg_t alg;
      begin
         ext = {d, d[7]};
         t = ext[8:3];
         rank = {fr[1] ^ y, fr[0] ^ x, x ^ y ^ fr[0]};
         if (bw)
            alg = PXE_ALG_BW_PIXEL;
         else if (d == `PXE_BYTE_MAX || d == `PXE_BYTE_MIN)
            alg = PXE_ALG_FULL_SUB;
         else if (t == '0)
            alg = PXE_ALG_LOW_END;
         else
            alg = PXE_ALG_DEFAULT;
         case (alg)
            PXE_ALG_DEFAULT: inc = (ext[2:0] > rank) && (t != '1);
            PXE_ALG_LOW_END: inc = (ext[2:0] > {y, x, x ^ y});
            PXE_ALG_BW_PIXEL: inc = 1'b0;
            PXE_ALG_FULL_SUB: inc = 1'b0;
            default: inc = 1'b0;
         endcase
         // Low end is spatial only: temporal flicker shows most near black
         return {t + {5'h00, inc}, `PXE_LOW2};
      end
   endfunction

   function automatic logic pxe_is_bw(input logic [7:0] r,
      input logic [7:0] g, input logic [7:0] b);
      begin
         return (r == g) && (g == b) &&
            (r == `PXE_BYTE_MAX || r == `PXE_BYTE_MIN);
      end
   endfunction

   // -------------------------------------------------------------------
   // Registers and table store
   // -------------------------------------------------------------------
   logic [7:0] page_reg, page_next, ctrl_reg, ctrl_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   pxe_load_t load_reg, load_next;
   logic [1:0] frame_reg, frame_next;
   logic [7:0] lut_mem [3][`PXE_TAB_ENTRIES];
   pxe_page_t page_sel;
   logic [1:0] tab_idx;
   logic tab_we, wb_on, page_wr;

   assign page_sel = pxe_page_t'(page_reg[`PXE_PG_HI:`PXE_PG_LO]);
   assign tab_idx = page_reg[`PXE_PG_HI:`PXE_PG_LO] - 2'h1;
   assign wb_on = page_reg[`PXE_WB_BIT];
   assign page_wr = i_reg_wr && (i_reg_addr == `PXE_PAGE_ADDR);
   // Table writes gated by load state and reload permission
   assign tab_we = i_reg_wr && !page_wr && (page_sel != PXE_PAGE_CFG) &&
      (load_reg == PXE_LD_INIT || ctrl_reg[`PXE_C_RELOAD]);

   always_comb
   begin
      page_next = page_reg;
      ctrl_next = ctrl_reg;
      load_next = load_reg;
      rdata_next = rdata_reg;
      rvalid_next = i_reg_rd;
      if (page_wr)
         page_next = i_reg_wdata;
      else if (i_reg_wr && page_sel == PXE_PAGE_CFG &&
         i_reg_addr == `PXE_CTRL_ADDR)
         ctrl_next = i_reg_wdata;
      case (load_reg)
         PXE_LD_INIT:
            if (page_wr && i_reg_wdata[`PXE_WB_BIT])
               load_next = PXE_LD_LOCKED;
         PXE_LD_LOCKED: load_next = PXE_LD_LOCKED;
         default: load_next = PXE_LD_INIT;
      endcase
      if (i_reg_rd)
      begin
         if (i_reg_addr == `PXE_PAGE_ADDR)
            rdata_next = page_reg;
         else if (page_sel != PXE_PAGE_CFG)
            rdata_next = lut_mem[tab_idx][i_reg_addr];
         else if (i_reg_addr == `PXE_CTRL_ADDR)
            rdata_next = ctrl_reg;
         else if (i_reg_addr == `PXE_STAT_ADDR)
            rdata_next = {5'h00, frame_reg, load_reg == PXE_LD_LOCKED};
         else
            rdata_next = `PXE_ZERO8;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         page_reg <= `PXE_PAGE_RST;
         ctrl_reg <= `PXE_CTRL_RST;
         load_reg <= PXE_LD_INIT;
         rdata_reg <= `PXE_ZERO8;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         page_reg <= page_next;
         ctrl_reg <= ctrl_next;
         load_reg <= load_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // Separate write and read ports keep a live reload glitch free
   always_ff @(posedge i_clk)
   begin
      if (tab_we)
         lut_mem[tab_idx][i_reg_addr] <= i_reg_wdata;
   end

   assign o_reg_rdata = rdata_reg;
   assign o_reg_rvalid = rvalid_reg;

   // -------------------------------------------------------------------
   // Frame and position tracking
   // -------------------------------------------------------------------
   logic x_reg, x_next, y_reg, y_next;
   logic hs_prev_reg, vs_prev_reg, de_prev_reg;
   logic hs_prev_next, vs_prev_next, de_prev_next;
   logic [15:0] gap_reg, gap_next;
   logic acc, hs_a, vs_a, de_a, frame_start, line_start;

   assign acc = i_pix_valid && o_pix_ready;
   assign hs_a = i_hsync ~^ ctrl_reg[`PXE_C_HSPOL];
   assign vs_a = i_vsync ~^ ctrl_reg[`PXE_C_VSPOL];
   assign de_a = i_de ~^ ctrl_reg[`PXE_C_DEPOL];
   assign line_start = ctrl_reg[`PXE_C_DEONLY] ? (de_a && !de_prev_reg) :
      (hs_a && !hs_prev_reg);
   assign frame_start = ctrl_reg[`PXE_C_DEONLY] ?
      (de_a && !de_prev_reg && gap_reg == FRAME_GAP) :
      (vs_a && !vs_prev_reg);

   always_comb
   begin
      frame_next = frame_reg;
      x_next = x_reg;
      y_next = y_reg;
      hs_prev_next = hs_prev_reg;
      vs_prev_next = vs_prev_reg;
      de_prev_next = de_prev_reg;
      gap_next = gap_reg;
      if (acc)
      begin
         hs_prev_next = hs_a;
         vs_prev_next = vs_a;
         de_prev_next = de_a;
         if (de_a)
            gap_next = '0;
         else if (gap_reg != FRAME_GAP)
            gap_next = gap_reg + 16'h0001;
         if (frame_start)
         begin
            frame_next = frame_reg + 2'h1;
            x_next = 1'b0;
            y_next = 1'b0;
         end
         else if (line_start)
         begin
            x_next = 1'b0;
            y_next = !y_reg;
         end
         else if (de_a)
            x_next = !x_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         frame_reg <= 2'h0;
         x_reg <= 1'b0;
         y_reg <= 1'b0;
         hs_prev_reg <= 1'b0;
         vs_prev_reg <= 1'b0;
         de_prev_reg <= 1'b0;
         gap_reg <= 16'h0000;
      end
      else
      begin
         frame_reg <= frame_next;
         x_reg <= x_next;
         y_reg <= y_next;
         hs_prev_reg <= hs_prev_next;
         vs_prev_reg <= vs_prev_next;
         de_prev_reg <= de_prev_next;
         gap_reg <= gap_next;
      end
   end

   // -------------------------------------------------------------------
   // Pipeline: pre-dither, table, post-dither
   // -------------------------------------------------------------------
   // Each stage word: {r, g, b, hs, vs, de, frame, x, y}
   logic [FW+3:0] s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next;
   logic v1_reg, v1_next, v2_reg, v2_next, v3_reg, v3_next;
   logic fifo_in_ready, fifo_out_valid, pop;
   logic [FW-1:0] fifo_out;
   logic [7:0] r1, g1, b1, r2, g2, b2;
   logic bw_in, bw_mid;

   // Whole pipe moves only when the FIFO has room; bubbles stall too
   assign o_pix_ready = fifo_in_ready;
   assign bw_in = pxe_is_bw(i_red, i_green, i_blue);
   assign {r1, g1, b1} = s1_reg[FW+3:7];
   assign {r2, g2, b2} = s2_reg[FW+3:7];
   assign bw_mid = pxe_is_bw(r2, g2, b2);

   always_comb
   begin
      s1_next = s1_reg;
      s2_next = s2_reg;
      s3_next = s3_reg;
      v1_next = v1_reg;
      v2_next = v2_reg;
      v3_next = v3_reg;
      if (fifo_in_ready)
      begin
         v1_next = i_pix_valid;
         v2_next = v1_reg;
         v3_next = v2_reg;
         s1_next = {i_red, i_green, i_blue, i_hsync, i_vsync, i_de,
            frame_reg, x_reg, y_reg};
         if (ctrl_reg[`PXE_C_PRE])
         begin
            s1_next[FW+3:FW-4] = pxe_dither(i_red, bw_in, frame_reg,
               x_reg, y_reg);
            s1_next[FW-5:FW-12] = pxe_dither(i_green, bw_in, frame_reg,
               x_reg, y_reg);
            s1_next[FW-13:FW-20] = pxe_dither(i_blue, bw_in, frame_reg,
               x_reg, y_reg);
         end
         s2_next = s1_reg;
         if (wb_on)
            s2_next[FW+3:7] = {lut_mem[0][r1], lut_mem[1][g1],
               lut_mem[2][b1]};
         s3_next = s2_reg;
         if (ctrl_reg[`PXE_C_POST])
         begin
            s3_next[FW+3:FW-4] = pxe_dither(r2, bw_mid, s2_reg[3:2],
               s2_reg[1], s2_reg[0]);
            s3_next[FW-5:FW-12] = pxe_dither(g2, bw_mid, s2_reg[3:2],
               s2_reg[1], s2_reg[0]);
            s3_next[FW-13:FW-20] = pxe_dither(b2, bw_mid, s2_reg[3:2],
               s2_reg[1], s2_reg[0]);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         v1_reg <= 1'b0;
         v2_reg <= 1'b0;
         v3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         v1_reg <= v1_next;
         v2_reg <= v2_next;
         v3_reg <= v3_next;
      end
   end

   pxenh_fifo
   #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_in_valid(v3_reg),
      .o_in_ready(fifo_in_ready),
      .i_in_data(s3_reg[FW+3:4]),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(pop),
      .o_out_data(fifo_out)
   );

   // -------------------------------------------------------------------
   // Output launch registers
   // -------------------------------------------------------------------
   logic [FW:0] rise_reg, rise_next, fall_reg, fall_next;

   assign pop = fifo_out_valid && (i_panel_ready || !rise_reg[FW]);

   always_comb
   begin
      rise_next = rise_reg;
      if (pop)
         rise_next = {1'b1, fifo_out};
      else if (i_panel_ready)
         rise_next[FW] = 1'b0;
      fall_next = rise_reg;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         rise_reg <= '0;
      else
         rise_reg <= rise_next;
   end

   // Falling copy delays launch half a period for panels on that edge
   always_ff @(negedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         fall_reg <= '0;
      else
         fall_reg <= fall_next;
   end

   assign {o_pix_valid, o_red, o_green, o_blue, o_hsync, o_vsync, o_de} =
      ctrl_reg[`PXE_C_EDGE] ? rise_reg : fall_reg;
endmodule // pxenh_top

// File: testbench/pxenh_asserts.sv
// Checker for the register and panel ports of the pixel stage
`include "pxenh_map.svh"

module pxenh_asserts
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic i_panel_ready,
   input wire logic o_pix_valid,
   input wire logic [7:0] o_red,
   input wire logic [7:0] o_green,
   input wire logic [7:0] o_blue
);
   // -------------------------------------------------------------------
   // Shadow of page, control and load state
   // -------------------------------------------------------------------
   logic [7:0] pg_reg, pg_next, ctl_reg, ctl_next;
   logic lk_reg, lk_next, rd_cfg;
   assign rd_cfg = i_reg_rd && !i_reg_wr && pg_reg[7:6] == 2'h0;
   always_comb
   begin
      pg_next = pg_reg;
      ctl_next = ctl_reg;
      lk_next = lk_reg;
      if (i_reg_wr && i_reg_addr == `PXE_PAGE_ADDR)
      begin
         pg_next = i_reg_wdata;
         lk_next = lk_reg | i_reg_wdata[`PXE_WB_BIT];
      end
      if (i_reg_wr && pg_reg[7:6] == 2'h0 && i_reg_addr == `PXE_CTRL_ADDR)
         ctl_next = i_reg_wdata;
   end
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         pg_reg <= `PXE_PAGE_RST;
         ctl_reg <= `PXE_CTRL_RST;
         lk_reg <= 1'b0;
      end
      else
      begin
         pg_reg <= pg_next;
         ctl_reg <= ctl_next;
         lk_reg <= lk_next;
      end
   end
   // -------------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_rd_answer; i_reg_rd |=> o_reg_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read not answered");
   property p_rd_quiet; !i_reg_rd |=> !o_reg_rvalid; endproperty
   a_rd_quiet: assert property (p_rd_quiet)
      else $error("read answer without read");
   property p_page_rb;
      i_reg_rd && !i_reg_wr && i_reg_addr == `PXE_PAGE_ADDR
         |=> o_reg_rdata == pg_reg;
   endproperty
   a_page_rb: assert property (p_page_rb)
      else $error("page readback wrong");
   property p_ctrl_rb;
      rd_cfg && i_reg_addr == `PXE_CTRL_ADDR |=> o_reg_rdata == ctl_reg;
   endproperty
   a_ctrl_rb: assert property (p_ctrl_rb)
      else $error("control readback wrong");
   property p_unmapped;
      rd_cfg && !(i_reg_addr inside {`PXE_PAGE_ADDR, `PXE_CTRL_ADDR,
         `PXE_STAT_ADDR}) |=> o_reg_rdata == `PXE_ZERO8;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_stat_lock;
      rd_cfg && i_reg_addr == `PXE_STAT_ADDR
         |=> o_reg_rdata[0] == lk_reg && o_reg_rdata[7:3] == 5'h00;
   endproperty
   a_stat_lock: assert property (p_stat_lock)
      else $error("status wrong");
   property p_hold;
      o_pix_valid && !i_panel_ready
         |=> o_pix_valid && $stable({o_red, o_green, o_blue});
   endproperty
   a_hold: assert property (p_hold)
      else $error("output word not held");
   property p_rst_idle;
      $rose(i_resetn) |-> !o_pix_valid && !o_reg_rvalid;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("outputs busy after reset");
endmodule // pxenh_asserts

bind pxenh_top pxenh_asserts u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .o_reg_rvalid(o_reg_rvalid), .i_panel_ready(i_panel_ready),
   .o_pix_valid(o_pix_valid), .o_red(o_red), .o_green(o_green),
   .o_blue(o_blue));

// File: testbench/pxenh_panel.sv
// Panel model: random stalls, records every accepted output word
module pxenh_panel
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_hold,
   input wire logic i_valid,
   input wire logic [26:0] i_word,
   output logic o_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [26:0] word_q[$];
   int pseed = 32'h1234;
   // Stalls one cycle in four so the FIFO is exercised
   always @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_ready <= 1'b0;
      else
      begin
         if (i_valid && o_ready)
            word_q.push_back(i_word);
         o_ready <= !i_hold && (($random(pseed) & 3) != 0);
      end
   end
endmodule // pxenh_panel

// File: testbench/tb.sv
// Self-checking bench for the pixel output and enhancement stage
`include "pxenh_map.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_resetn, i_reg_wr, i_reg_rd, i_pix_valid, hold;
   logic i_hsync, i_vsync, i_de, i_panel_ready, o_reg_rvalid, o_pix_ready;
   logic o_pix_valid, o_hsync, o_vsync, o_de;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rv;
   logic [7:0] i_red, i_green, i_blue, o_red, o_green, o_blue;
   logic [7:0] tab [3][256];
   logic [26:0] exp_q[$];
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 32'he09e;

   pxenh_top #(.FRAME_GAP(16'h0004), .FIFO_DEPTH(8)) uut (.i_clk(i_clk),
      .i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_pix_valid(i_pix_valid), .o_pix_ready(o_pix_ready), .i_red(i_red),
      .i_green(i_green), .i_blue(i_blue), .i_hsync(i_hsync),
      .i_vsync(i_vsync), .i_de(i_de), .i_panel_ready(i_panel_ready),
      .o_pix_valid(o_pix_valid), .o_red(o_red), .o_green(o_green),
      .o_blue(o_blue), .o_hsync(o_hsync), .o_vsync(o_vsync), .o_de(o_de));
   pxenh_panel pan (.i_clk(i_clk), .i_resetn(i_resetn), .i_hold(hold),
      .i_valid(o_pix_valid), .o_ready(i_panel_ready),
      .i_word({o_red, o_green, o_blue, o_hsync, o_vsync, o_de}));

   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task chk(input string nm, input logic [26:0] e, input logic [26:0] g);
      n_compared++;
      if (e !== g)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   task end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      @(negedge i_clk);
      chk("rvalid", 27'h1, {26'h0, o_reg_rvalid});
      d = o_reg_rdata;
      @(posedge i_clk);
   endtask
   // Pixel 0 is all zero, pixel 1 all ones; entry 0x2a is never indexed
   task burst(input int n, input bit wb);
      logic [7:0] c [3];
      logic [2:0] s;
      for (int i = 0; i < n; i++)
      begin
         foreach (c[k])
         begin
            c[k] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            if (wb && c[k] == 8'h2a)
               c[k] = 8'h2b;
         end
         s = 3'($random(seed));
         i_pix_valid <= 1'b1;
         i_red <= c[0];
         i_green <= c[1];
         i_blue <= c[2];
         {i_hsync, i_vsync, i_de} <= s;
         exp_q.push_back({c[0], c[1], c[2], s});
         @(posedge i_clk);
         while (o_pix_ready !== 1'b1)
            @(posedge i_clk);
      end
      i_pix_valid <= 1'b0;
   endtask
   // Mode 0 plain, 1 lookup, 2 lookup then dither, 3 dither only
   task drain(input int mode);
      logic [26:0] e, g;
      logic [7:0] t, o;
      logic [6:0] dif;
      for (int w = 0; w < 600 && pan.word_q.size() < exp_q.size(); w++)
         @(posedge i_clk);
      chk("count", 27'(exp_q.size()), 27'(pan.word_q.size()));
      while (exp_q.size() > 0 && pan.word_q.size() > 0)
      begin
         e = exp_q.pop_front();
         g = pan.word_q.pop_front();
         for (int k = 0; k < 3 && (mode == 1 || mode == 2); k++)
            e[26-8*k -: 8] = tab[k][e[26-8*k -: 8]];
         if (mode < 2)
            chk("word", e, g);
         else
         begin
            chk("sync", e[2:0], g[2:0]);
            for (int k = 0; k < 3; k++)
            begin
               t = e[26-8*k -: 8];
               o = g[26-8*k -: 8];
               dif = {1'b0, o[7:2]} - {1'b0, t[7:2]};
               chk("dither", 1, o[1:0] == 2'h0 && dif < 7'h2);
            end
         end
      end
   endtask

   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   initial
   begin
      {i_resetn, i_reg_wr, i_reg_rd, i_pix_valid, hold} = 5'h0;
      {i_hsync, i_vsync, i_de, i_reg_addr, i_reg_wdata} = 19'h0;
      {i_red, i_green, i_blue} = 24'h0;
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      rd(`PXE_PAGE_ADDR, rv);
      chk("page reset", 8'h00, rv);
      rd(`PXE_CTRL_ADDR, rv);
      chk("ctrl reset", 8'he1, rv);
      rd(8'h10, rv);
      chk("unmapped", 8'h00, rv);
      $display("Reset test done");
      hold <= 1'b1;
      fork
         burst(40, 0);
         begin
            for (int w = 0; w < 60 && o_pix_ready === 1'b1; w++)
               @(posedge i_clk);
            chk("full", 0, o_pix_ready);
            chk("stalled", 0, 27'(pan.word_q.size()));
            hold <= 1'b0;
         end
      join
      drain(0);
      wr(`PXE_CTRL_ADDR, 8'he0);
      burst(30, 0);
      drain(0);
      $display("Pass-through test done");
      for (int p = 0; p < 3; p++)
      begin
         wr(`PXE_PAGE_ADDR, 8'(p + 1) << 6);
         for (int i = 0; i < 256; i++)
            if (i != 8'h2a)
            begin
               tab[p][i] = 8'($random(seed));
               wr(8'(i), tab[p][i]);
            end
      end
      for (int i = 0; i < 256; i += 51)
         begin
            rd(8'(i), rv);
            chk("blue entry", tab[2][i], rv);
         end
      wr(`PXE_PAGE_ADDR, 8'h20);
      rd(`PXE_STAT_ADDR, rv);
      chk("locked", 1, rv[0]);
      burst(60, 1);
      drain(1);
      wr(`PXE_PAGE_ADDR, 8'h60);
      wr(8'h05, ~tab[0][5]);
      rd(8'h05, rv);
      chk("refused", tab[0][5], rv);
      wr(`PXE_PAGE_ADDR, 8'h20);
      wr(`PXE_CTRL_ADDR, 8'he9);
      wr(`PXE_PAGE_ADDR, 8'h60);
      tab[0][5] = 8'h98;
      wr(8'h05, tab[0][5]);
      rd(8'h05, rv);
      chk("reload", tab[0][5], rv);
      burst(40, 1);
      drain(1);
      $display("Table test done");
      wr(`PXE_PAGE_ADDR, 8'h20);
      wr(`PXE_CTRL_ADDR, 8'he5);
      burst(60, 1);
      drain(2);
      wr(`PXE_PAGE_ADDR, 8'h00);
      wr(`PXE_CTRL_ADDR, 8'hf3);
      burst(30, 0);
      drain(3);
      wr(`PXE_CTRL_ADDR, 8'he1);
      burst(30, 0);
      drain(0);
      $display("Dither test done");
      end_of_test;
   end

   initial
   begin
      #(40 * 40000);
      error_cnt++;
      end_of_test;
   end
endmodule // tb
